// >>> rtl/blc_ctrl.sv
// blc_ctrl.sv - black level correction control: registers, line counting, clamp timing
// assumes one pixel per clock, inputs synchronous to clock, a master that never waits
//
// Summary of operation
// - the line field runs the loop forever (00) or for 15, 31 or 63 lines.
// - any write to the correction configuration register clears the line counter.
// - each line-start pulse counts as one new line for the loop.
// - pixel code averages 4 to 32 pixels and integration code divides error by 8 to 64.
// - mode 00 disables auto clamping, 01 triggers on the line-start falling edge, 11 reserved.
// - mode 10 times the clamp pulse from the falling edge of the input clamp pulse.
// - while auto clamping is on the offset dac is updated only by the loop, host writes ignored.
// - a seven-bit delay in pixels places the clamp pulse after the trigger edge, bit 7 reserved.
// - the upper eight target bits come from the target high register, reset 0x20.
// - the lower two target bits come from target low bits 1:0, bits 7:2 reserved.
// - a five-bit position places the red clamp pulse, zero selects the fixed default RED_DEF_POS.
// - dac values use offset binary, midscale meaning zero offset.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`include "blc_map.svh"
module blc_ctrl #(
   parameter logic [4:0] RED_DEF_POS = `BLC_RED_DEF_POS // red clamp slot when position is zero
) (
   input wire logic clock, // pixel clock, 100 MHz
   input wire logic reset, // async, active high
   input wire logic [7:0] reg_addr, // register address
   input wire logic [7:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [7:0] reg_rdata, // read data, cycle after strobe
   input wire logic line_start_pulse, // line-start pulse
   input wire logic input_clamp_pulse, // input clamp pulse
   input wire logic [9:0] black_pixel, // black pixel code from the converter
   output logic black_clamp_pulse, // auto black clamp window
   output logic red_clamp_pulse, // red channel clamp pulse
   output logic [9:0] offset_dac, // offset dac value, offset binary
   output logic loop_running // loop active
);
   logic [7:0] cfg_ff, nxt_cfg;
   logic [6:0] dly_ff, nxt_dly;
   logic [7:0] tgh_ff, nxt_tgh;
   logic [1:0] tgl_ff, nxt_tgl;
   logic [4:0] rcp_ff, nxt_rcp;
   logic [5:0] lines_ff, nxt_lines;
   logic ls_prev_ff, nxt_ls_prev;
   logic run_ff, nxt_run;
   logic [4:0] red_cnt_ff, nxt_red_cnt;
   logic red_ff, nxt_red;
   logic [7:0] rdata_ff, nxt_rdata;
   logic wr_cfg;
   logic auto_en;
   logic ls_rise;
   logic ls_fall;
   logic lines_done;
   logic dac_wr;
   logic [9:0] dac_val;
   logic [9:0] dac_ld;
   logic [9:0] target;

   // last line of a finite run, zero when the run is unbounded
   function automatic logic [5:0] lines_limit(input logic [1:0] code);
      case (code)
         2'h1: lines_limit = 6'h0f;
         2'h2: lines_limit = 6'h1f;
         2'h3: lines_limit = 6'h3f;
         default: lines_limit = 6'h00;
      endcase
   endfunction

   // write decode and loop state terms
   always_comb begin
      wr_cfg = reg_wr && (reg_addr == `BLC_ADDR_CFG);
      auto_en = (cfg_ff[`BLC_F_MODE] != blc_pkg::BLC_OFF);
      ls_rise = line_start_pulse & ~ls_prev_ff;
      ls_fall = ls_prev_ff & ~line_start_pulse;
      lines_done = (cfg_ff[`BLC_F_LINES] != 2'h0)
         && (lines_ff >= lines_limit(cfg_ff[`BLC_F_LINES]));
      target = {tgh_ff, tgl_ff};
      // host dac writes only land while the loop owns nothing
      dac_wr = reg_wr && !auto_en
         && (reg_addr == `BLC_ADDR_DACH || reg_addr == `BLC_ADDR_DACL);
      dac_ld = (reg_addr == `BLC_ADDR_DACH) ? {reg_wdata, dac_val[1:0]}
         : {dac_val[9:2], reg_wdata[1:0]};
   end

   // configuration registers
   always_comb begin
      nxt_cfg = cfg_ff;
      nxt_dly = dly_ff;
      nxt_tgh = tgh_ff;
      nxt_tgl = tgl_ff;
      nxt_rcp = rcp_ff;
      if (reg_wr) begin
         case (reg_addr)
            `BLC_ADDR_CFG: nxt_cfg = reg_wdata;
            `BLC_ADDR_DLY: nxt_dly = reg_wdata[`BLC_F_DLY];
            `BLC_ADDR_TGH: nxt_tgh = reg_wdata;
            `BLC_ADDR_TGL: nxt_tgl = reg_wdata[`BLC_F_TGL];
            `BLC_ADDR_RCP: nxt_rcp = reg_wdata[`BLC_F_RCP];
            default: nxt_cfg = cfg_ff;
         endcase
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cfg_ff <= `BLC_RST_CFG;
         dly_ff <= `BLC_RST_DLY;
         tgh_ff <= `BLC_RST_TGH;
         tgl_ff <= `BLC_RST_TGL;
         rcp_ff <= `BLC_RST_RCP;
      end else begin
         cfg_ff <= nxt_cfg;
         dly_ff <= nxt_dly;
         tgh_ff <= nxt_tgh;
         tgl_ff <= nxt_tgl;
         rcp_ff <= nxt_rcp;
      end
   end

   // line counter; a config write restarts a finite run even mid-line
   always_comb begin
      nxt_ls_prev = line_start_pulse;
      nxt_lines = lines_ff;
      if (wr_cfg) begin
         nxt_lines = 6'h00;
      end else if (ls_rise && run_ff && (cfg_ff[`BLC_F_LINES] != 2'h0)) begin
         nxt_lines = 6'(lines_ff + 6'h01);
      end
      nxt_run = (cfg_ff[`BLC_F_MODE] == blc_pkg::BLC_FROM_LINE
         || cfg_ff[`BLC_F_MODE] == blc_pkg::BLC_FROM_CLAMP) && !lines_done;
      if (wr_cfg) begin
         nxt_run = 1'b0; // settle one cycle on the new setting
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ls_prev_ff <= 1'b0;
         lines_ff <= 6'h00;
         run_ff <= 1'b0;
      end else begin
         ls_prev_ff <= nxt_ls_prev;
         lines_ff <= nxt_lines;
         run_ff <= nxt_run;
      end
   end

   // red clamp: counts down from the line-start falling edge
   // a new fall reloads the count, so a short line never stacks two pulses
   always_comb begin
      nxt_red_cnt = red_cnt_ff;
      nxt_red = 1'b0;
      if (ls_fall) begin
         nxt_red_cnt = (rcp_ff == 5'h00) ? RED_DEF_POS : rcp_ff;
      end else if (red_cnt_ff != 5'h00) begin
         nxt_red_cnt = 5'(red_cnt_ff - 5'h01);
         nxt_red = (red_cnt_ff == 5'h01);
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         red_cnt_ff <= 5'h00;
         red_ff <= 1'b0;
      end else begin
         red_cnt_ff <= nxt_red_cnt;
         red_ff <= nxt_red;
      end
   end

   // read port: unmapped and reserved bits read zero
   always_comb begin
      case (reg_addr)
         `BLC_ADDR_CFG: nxt_rdata = cfg_ff;
         `BLC_ADDR_DLY: nxt_rdata = {1'b0, dly_ff};
         `BLC_ADDR_TGH: nxt_rdata = tgh_ff;
         `BLC_ADDR_TGL: nxt_rdata = {6'h00, tgl_ff};
         `BLC_ADDR_RCP: nxt_rdata = {3'h0, rcp_ff};
         `BLC_ADDR_DACH: nxt_rdata = dac_val[9:2];
         `BLC_ADDR_DACL: nxt_rdata = {6'h00, dac_val[1:0]};
         `BLC_ADDR_STAT: nxt_rdata = {run_ff, 1'b0, lines_ff};
         default: nxt_rdata = 8'h00;
      endcase
      if (!reg_rd) begin
         nxt_rdata = 8'h00;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // window generator and integrator
   // the window doubles as the clamp output, so pulse and averaging always agree
   blc_loop_if lp ();
   assign lp.pix_code = cfg_ff[`BLC_F_PIX];

   blc_clamp_gen u_gen (
      .clock(clock),
      .reset(reset),
      .run(run_ff),
      .mode(cfg_ff[`BLC_F_MODE]),
      .delay(dly_ff),
      .line_start(line_start_pulse),
      .clamp_in(input_clamp_pulse),
      .lp(lp.gen)
   );

   blc_loop_acc u_acc (
      .clock(clock),
      .reset(reset),
      .lp(lp.acc),
      .sample(black_pixel),
      .target(target),
      .int_code(cfg_ff[`BLC_F_INT]),
      .ld_en(dac_wr),
      .ld_val(dac_ld),
      .dac(dac_val)
   );

   // outputs, each from a flip-flop
   assign reg_rdata = rdata_ff;
   assign black_clamp_pulse = lp.win;
   assign red_clamp_pulse = red_ff;
   assign offset_dac = dac_val;
   assign loop_running = run_ff;

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   // line counting and run length
   a_cfg_clears_lines: assert property (wr_cfg |=> lines_ff == 6'h00)
      else $error("config write did not clear line counter");
   a_cfg_drops_run: assert property (wr_cfg |=> !run_ff)
      else $error("loop kept running through a config write");
   a_line_limit: assert property (cfg_ff[`BLC_F_LINES] != 2'h0 && !wr_cfg
      |-> lines_ff <= lines_limit(cfg_ff[`BLC_F_LINES]))
      else $error("line counter passed the run length");
   a_line_stop: assert property (lines_done ##1 !wr_cfg |-> !run_ff)
      else $error("loop kept running after last line");
   a_line_count: assert property (ls_rise && run_ff && !wr_cfg && cfg_ff[7:6] != 2'h0
      |=> lines_ff == 6'($past(lines_ff) + 6'h01))
      else $error("line-start pulse not counted");
   a_mode_off_idle: assert property (cfg_ff[`BLC_F_MODE] == 2'h0 |=> !run_ff)
      else $error("loop running with auto clamp disabled");
   a_run_needs_mode: assert property (run_ff
      |-> (cfg_ff[`BLC_F_MODE] == 2'h1 || cfg_ff[`BLC_F_MODE] == 2'h2))
      else $error("loop running in a mode that has no trigger");

   // dac ownership between host and loop
   a_dac_locked: assert property (reg_wr && auto_en && !lp.done
      && (reg_addr == `BLC_ADDR_DACH || reg_addr == `BLC_ADDR_DACL)
      |=> $stable(offset_dac))
      else $error("host write reached dac in auto mode");
   a_dac_host_load: assert property (reg_wr && !auto_en && !lp.done
      && reg_addr == `BLC_ADDR_DACH
      |=> offset_dac[9:2] == $past(reg_wdata))
      else $error("host dac write lost while auto clamp off");

   // target, read back and reserved bits
   a_tgh_to_target: assert property (reg_wr && reg_addr == `BLC_ADDR_TGH
      |=> target[9:2] == $past(reg_wdata))
      else $error("target high bits not taken from register");
   a_tgl_to_target: assert property (reg_wr && reg_addr == `BLC_ADDR_TGL
      |=> target[1:0] == $past(reg_wdata[1:0]))
      else $error("target low bits not taken from register");
   a_tgl_reserved: assert property (reg_rd && reg_addr == `BLC_ADDR_TGL
      |=> reg_rdata[7:2] == 6'h00)
      else $error("reserved target low bits read nonzero");
   a_dly_reserved: assert property (reg_rd && reg_addr == `BLC_ADDR_DLY
      |=> reg_rdata[7] == 1'b0)
      else $error("reserved delay bit read nonzero");
   a_cfg_readback: assert property (reg_rd && reg_addr == `BLC_ADDR_CFG
      |=> reg_rdata == $past(cfg_ff))
      else $error("config register read back wrong");
   a_stat_read: assert property (reg_rd && reg_addr == `BLC_ADDR_STAT
      |=> reg_rdata == {$past(run_ff), 1'b0, $past(lines_ff)})
      else $error("status read does not show run and line count");
   // read data stand one cycle only, so an idle bus reads as zero
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data present without a read strobe");

   // red clamp slot
   a_red_default: assert property (ls_fall && rcp_ff == 5'h00
      |=> red_cnt_ff == RED_DEF_POS)
      else $error("zero red position did not pick the default");
   a_red_slot: assert property (ls_fall && rcp_ff != 5'h00
      |=> red_cnt_ff == $past(rcp_ff))
      else $error("red position not loaded at line-start fall");
   a_red_one_shot: assert property (red_clamp_pulse |=> !red_clamp_pulse)
      else $error("red clamp pulse longer than one cycle");

   c_line_run_ends: cover property (run_ff ##1 lines_done);
   c_red_pulse: cover property ($rose(red_clamp_pulse));
   c_host_dac_write: cover property (dac_wr);
endmodule

// >>> rtl/blc_map.svh
// blc_map.svh - register offsets, field positions, reset values of the black level loop
// assumes an 8-bit register port with byte-wide registers
`ifndef BLC_MAP_SVH
`define BLC_MAP_SVH
`define BLC_ADDR_CFG 8'h08
`define BLC_ADDR_DLY 8'h09
`define BLC_ADDR_TGH 8'h0a
`define BLC_ADDR_TGL 8'h0b
`define BLC_ADDR_RCP 8'h0c
`define BLC_ADDR_DACH 8'h10
`define BLC_ADDR_DACL 8'h11
`define BLC_ADDR_STAT 8'h12
`define BLC_F_LINES 7:6
`define BLC_F_PIX 5:4
`define BLC_F_INT 3:2
`define BLC_F_MODE 1:0
`define BLC_F_DLY 6:0
`define BLC_F_TGL 1:0
`define BLC_F_RCP 4:0
`define BLC_RST_CFG 8'h00
`define BLC_RST_DLY 7'h00
`define BLC_RST_TGH 8'h20
`define BLC_RST_TGL 2'h0
`define BLC_RST_RCP 5'h00
`define BLC_RST_DAC 10'h200
`define BLC_RED_DEF_POS 5'h04
`endif

// >>> rtl/blc_pkg.sv
// blc_pkg.sv - types shared by the black level loop modules
// assumes nothing beyond the tools' package support
package blc_pkg;
   typedef enum logic [2:0] {
      BLC_IDLE = 3'h1,
      BLC_DELAY = 3'h2,
      BLC_WIN = 3'h4
   } blc_state_e;
   typedef enum logic [1:0] {
      BLC_OFF = 2'h0,
      BLC_FROM_LINE = 2'h1,
      BLC_FROM_CLAMP = 2'h2,
      BLC_RSVD = 2'h3
   } blc_mode_e;
endpackage

// >>> rtl/blc_loop_if.sv
// blc_loop_if.sv - clamp window handshake between pulse generator and loop accumulator
// assumes both ends share the pixel clock
`timescale 1ns/1ns
interface blc_loop_if;
   logic [1:0] pix_code; // pixel averaging code
   logic win; // clamp window, one black pixel per cycle
   logic done; // one cycle after the last window pixel
   modport gen (input pix_code, output win, output done);
   modport acc (input pix_code, input win, input done);
endinterface

// >>> rtl/blc_clamp_gen.sv
// blc_clamp_gen.sv - places the black clamp window after the selected trigger edge
// assumes one pixel per clock and trigger inputs synchronous to the clock
`timescale 1ns/1ns
module blc_clamp_gen (
   input wire logic clock, // pixel clock
   input wire logic reset, // async, active high
   input wire logic run, // loop may start a new window
   input wire logic [1:0] mode, // trigger source select
   input wire logic [6:0] delay, // pixels from trigger edge to window
   input wire logic line_start, // line-start pulse
   input wire logic clamp_in, // input clamp pulse
   blc_loop_if.gen lp // window toward the accumulator
);
   blc_pkg::blc_state_e state_ff, nxt_state;
   logic [6:0] cnt_ff, nxt_cnt;
   logic trig_prev_ff, nxt_trig_prev;
   logic win_ff, nxt_win;
   logic done_ff, nxt_done;
   logic trig;
   logic fall;
   logic [6:0] npix_m1;

   // trigger edge and window length decode
   always_comb begin
      trig = (mode == blc_pkg::BLC_FROM_CLAMP) ? clamp_in : line_start;
      fall = trig_prev_ff & ~trig;
      npix_m1 = 7'((7'h04 << lp.pix_code) - 7'h01);
   end

   // sequencer: wait edge, count delay, hold window
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_trig_prev = trig;
      nxt_done = 1'b0;
      case (state_ff)
         blc_pkg::BLC_IDLE: begin
            if (run && fall) begin
               if (delay == 7'h00) begin
                  nxt_state = blc_pkg::BLC_WIN;
                  nxt_cnt = npix_m1;
               end else begin
                  nxt_state = blc_pkg::BLC_DELAY;
                  nxt_cnt = 7'(delay - 7'h01);
               end
            end
         end
         blc_pkg::BLC_DELAY: begin
            if (cnt_ff == 7'h00) begin
               nxt_state = blc_pkg::BLC_WIN;
               nxt_cnt = npix_m1;
            end else begin
               nxt_cnt = 7'(cnt_ff - 7'h01);
            end
         end
         blc_pkg::BLC_WIN: begin
            if (cnt_ff == 7'h00) begin
               nxt_state = blc_pkg::BLC_IDLE;
               nxt_done = 1'b1;
            end else begin
               nxt_cnt = 7'(cnt_ff - 7'h01);
            end
         end
         default: begin
            nxt_state = blc_pkg::BLC_IDLE;
            nxt_cnt = 7'h00;
         end
      endcase
      nxt_win = (nxt_state == blc_pkg::BLC_WIN);
   end

   // state registers
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_ff <= blc_pkg::BLC_IDLE;
         cnt_ff <= 7'h00;
         trig_prev_ff <= 1'b0;
         win_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         trig_prev_ff <= nxt_trig_prev;
         win_ff <= nxt_win;
         done_ff <= nxt_done;
      end
   end

   assign lp.win = win_ff;
   assign lp.done = done_ff;

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   a_idle_needs_run: assert property (state_ff == blc_pkg::BLC_IDLE && !run |=> !win_ff)
      else $error("window opened while loop not running");
   a_clamp_trigger: assert property (state_ff == blc_pkg::BLC_IDLE && run
      && mode == blc_pkg::BLC_FROM_CLAMP && trig_prev_ff && !clamp_in
      |=> state_ff != blc_pkg::BLC_IDLE)
      else $error("clamp input falling edge not taken as trigger");
   a_delay_exact: assert property (state_ff == blc_pkg::BLC_DELAY && cnt_ff == 7'h00
      |=> win_ff)
      else $error("window did not follow end of delay");
   a_win_min_len: assert property ($rose(win_ff) |-> win_ff[*4])
      else $error("window shorter than four pixels");
   c_clamp_window: cover property (mode == blc_pkg::BLC_FROM_CLAMP && $rose(win_ff));
endmodule

// >>> rtl/blc_loop_acc.sv
// blc_loop_acc.sv - averages window pixels and integrates the error into the offset dac
// assumes the window carries one black pixel per clock on sample
`timescale 1ns/1ns
`include "blc_map.svh"
module blc_loop_acc (
   input wire logic clock, // pixel clock
   input wire logic reset, // async, active high
   blc_loop_if.acc lp, // window from the pulse generator
   input wire logic [9:0] sample, // black pixel code
   input wire logic [9:0] target, // black target code
   input wire logic [1:0] int_code, // integration divisor code
   input wire logic ld_en, // host load of the dac value
   input wire logic [9:0] ld_val, // value loaded by the host
   output logic [9:0] dac // offset dac, offset binary
);
   logic [14:0] sum_ff, nxt_sum;
   logic [9:0] dac_ff, nxt_dac;
   logic [9:0] avg;
   logic signed [10:0] err;
   logic signed [10:0] step;
   logic signed [11:0] trial;

   // average, error and scaled step
   always_comb begin
      avg = 10'(sum_ff >> (3'h2 + 3'(lp.pix_code)));
      err = $signed({1'b0, target}) - $signed({1'b0, avg});
      step = err >>> (3'h3 + 3'(int_code));
      trial = $signed({2'b00, dac_ff}) + 12'(step);
   end

   // accumulate during window, integrate at its end
   always_comb begin
      nxt_sum = sum_ff;
      nxt_dac = dac_ff;
      if (lp.win) begin
         nxt_sum = 15'(sum_ff + {5'h00, sample});
      end
      if (lp.done) begin
         nxt_sum = 15'h0000;
         // saturate so the offset binary code never wraps past 10'h000 or 10'h3ff
         if (trial < 0) begin
            nxt_dac = 10'h000;
         end else if (trial > 12'sh3ff) begin
            nxt_dac = 10'h3ff;
         end else begin
            nxt_dac = trial[9:0];
         end
      end else if (ld_en) begin
         nxt_dac = ld_val;
      end
   end

   // loop registers
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sum_ff <= 15'h0000;
         dac_ff <= `BLC_RST_DAC;
      end else begin
         sum_ff <= nxt_sum;
         dac_ff <= nxt_dac;
      end
   end

   assign dac = dac_ff;

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   a_err_zero_hold: assert property (lp.done && err == 11'sh000 |=> $stable(dac_ff))
      else $error("dac moved although average met target");
   a_no_wrap_up: assert property (lp.done && err > 11'sh000 |=> dac_ff >= $past(dac_ff))
      else $error("dac moved the wrong way or wrapped");
   c_dac_update: cover property (lp.done && step != 11'sh000);
endmodule

// >>> tb/test_black_level_correction_ctrl.sv
// self-checking bench for the black level correction control block
// assumes the block alone on a 100 MHz clock, the bench driving every port itself
`timescale 1ns/1ns
`include "blc_map.svh"
module test_black_level_correction_ctrl;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic line_start_pulse = 1'b0;
   logic input_clamp_pulse = 1'b0;
   logic [9:0] black_pixel = 10'h000;
   logic black_clamp_pulse;
   logic red_clamp_pulse;
   logic [9:0] offset_dac;
   logic loop_running;
   int mismatches = 0;
   int n_checks = 0;
   int t_win;
   int t_red;
   int width;

   // pixel clock, 10 ns period
   always #5 clock = ~clock;

   blc_ctrl DUT (
      .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .line_start_pulse(line_start_pulse), .input_clamp_pulse(input_clamp_pulse),
      .black_pixel(black_pixel), .black_clamp_pulse(black_clamp_pulse),
      .red_clamp_pulse(red_clamp_pulse), .offset_dac(offset_dac),
      .loop_running(loop_running)
   );

   // verdict in one place; also reached by the watchdog
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one-cycle write strobe, released at the edge that takes it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe, so sample mid-cycle there
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      chk(16'(reg_rdata), 16'(exp));
   endtask

   // pulse a trigger, then watch a fixed span long enough for delay 127 plus 32 pixels
   task automatic fire(input logic use_clamp);
      int t;
      t_win = -1;
      t_red = -1;
      width = 0;
      @(posedge clock);
      input_clamp_pulse <= use_clamp;
      line_start_pulse <= !use_clamp;
      repeat (2) @(posedge clock);
      input_clamp_pulse <= 1'b0;
      line_start_pulse <= 1'b0;
      for (t = 0; t < 200; t++) begin
         @(negedge clock);
         if (black_clamp_pulse === 1'b1) begin
            if (t_win < 0) t_win = t;
            width++;
         end
         if (red_clamp_pulse === 1'b1 && t_red < 0) t_red = t;
      end
   endtask

   // reset values, reserved bits, unmapped place
   task automatic s_regs();
      chk(16'(offset_dac), 16'h0200);
      rchk(`BLC_ADDR_CFG, 8'h00);
      rchk(`BLC_ADDR_DLY, 8'h00);
      rchk(`BLC_ADDR_TGH, 8'h20);
      rchk(`BLC_ADDR_TGL, 8'h00);
      rchk(`BLC_ADDR_RCP, 8'h00);
      rchk(`BLC_ADDR_DACH, 8'h80);
      wr(`BLC_ADDR_DLY, 8'hff);
      wr(`BLC_ADDR_TGL, 8'hff);
      wr(`BLC_ADDR_RCP, 8'hff);
      wr(`BLC_ADDR_TGH, 8'h5a);
      wr(8'h3c, 8'hff);
      rchk(`BLC_ADDR_DLY, 8'h7f);
      rchk(`BLC_ADDR_TGL, 8'h03);
      rchk(`BLC_ADDR_RCP, 8'h1f);
      rchk(`BLC_ADDR_TGH, 8'h5a);
      rchk(8'h3c, 8'h00);
      wr(`BLC_ADDR_DLY, 8'h00);
      wr(`BLC_ADDR_TGL, 8'h00);
      wr(`BLC_ADDR_RCP, 8'h00);
      wr(`BLC_ADDR_TGH, 8'h20);
   endtask

   // host dac writes land only while auto clamping is off
   task automatic s_lock();
      logic [7:0] m;
      wr(`BLC_ADDR_DACH, 8'h55);
      wr(`BLC_ADDR_DACL, 8'h03);
      @(negedge clock);
      chk(16'(offset_dac), 16'h0157);
      for (int i = 1; i < 4; i++) begin
         m = 8'(i);
         wr(`BLC_ADDR_CFG, m);
         wr(`BLC_ADDR_DACH, 8'h00);
         wr(`BLC_ADDR_DACL, 8'h00);
         @(negedge clock);
         chk(16'(offset_dac), 16'h0157);
         rchk(`BLC_ADDR_DACH, 8'h55);
      end
      wr(`BLC_ADDR_CFG, 8'h00);
      wr(`BLC_ADDR_DACH, 8'h80);
      wr(`BLC_ADDR_DACL, 8'h00);
   endtask

   // trigger source per mode, delay steps, window width, red clamp slot
   task automatic s_timing();
      int base;
      for (int m = 0; m < 4; m++) begin
         wr(`BLC_ADDR_CFG, 8'(m));
         fire(1'b0);
         chk(16'(t_win >= 0), 16'(m == 1));
         fire(1'b1);
         chk(16'(t_win >= 0), 16'(m == 2));
      end
      wr(`BLC_ADDR_CFG, 8'h01);
      fire(1'b0);
      base = t_win;
      chk(16'(t_red - t_win), 16'(`BLC_RED_DEF_POS));
      wr(`BLC_ADDR_RCP, 8'h07);
      fire(1'b0);
      chk(16'(t_red - t_win), 16'h0007);
      wr(`BLC_ADDR_DLY, 8'h05);
      fire(1'b0);
      chk(16'(t_win - base), 16'h0005);
      wr(`BLC_ADDR_DLY, 8'h7f);
      fire(1'b1 ^ 1'b1);
      chk(16'(t_win - base), 16'h007f);
      wr(`BLC_ADDR_DLY, 8'h00);
      for (int p = 0; p < 4; p++) begin
         wr(`BLC_ADDR_CFG, 8'(p * 16 + 1));
         fire(1'b0);
         chk(16'(width), 16'(4 << p));
      end
   endtask

   // each window adds the scaled error to the dac; target 0x080 by reset
   task automatic s_integ();
      int exp_dac;
      int err;
      exp_dac = 'h200;
      // earlier windows moved the dac, so park it at midscale with the loop off
      wr(`BLC_ADDR_CFG, 8'h00);
      wr(`BLC_ADDR_DACH, 8'h80);
      wr(`BLC_ADDR_DACL, 8'h00);
      for (int i = 0; i < 5; i++) begin
         err = (i < 4) ? 64 : -64;
         black_pixel <= (i < 4) ? 10'h040 : 10'h0c0;
         wr(`BLC_ADDR_CFG, 8'((i % 4) * 4 + 1));
         fire(1'b0);
         exp_dac = exp_dac + (err >>> (3 + i % 4));
         chk(16'(offset_dac), 16'(exp_dac));
      end
      black_pixel <= 10'h000;
   endtask

   // line counts per line-field code, stop at the end, restart on a config write
   task automatic s_lines();
      int n;
      for (int c = 0; c < 4; c++) begin
         n = (c == 0) ? 64 : (16 << (c - 1)) - 1;
         wr(`BLC_ADDR_CFG, 8'(c * 64 + 1));
         for (int k = 1; k <= n; k++) begin
            @(posedge clock);
            line_start_pulse <= 1'b1;
            repeat (2) @(posedge clock);
            line_start_pulse <= 1'b0;
            repeat (10) @(posedge clock);
            if (k == n - 1) begin
               @(negedge clock);
               chk(16'(loop_running), 16'h0001);
            end
         end
         @(negedge clock);
         chk(16'(loop_running), 16'(c == 0));
         if (c != 0) begin
            rchk(`BLC_ADDR_STAT, 8'(n));
            fire(1'b0);
            chk(16'(t_win >= 0), 16'h0000);
            wr(`BLC_ADDR_CFG, 8'(c * 64 + 1));
            repeat (3) @(posedge clock);
            rchk(`BLC_ADDR_STAT, 8'h80);
         end
      end
   endtask

   // main sequence after a 12-cycle reset
   initial begin
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      s_regs();
      s_lock();
      s_timing();
      s_integ();
      s_lines();
      stop_test();
   end

   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (100000) @(posedge clock);
      mismatches++;
      stop_test();
   end
endmodule
